// [hdl/nidc_node.sv]
// Node access: duplicate address check, receive filter and transmit gate
`timescale 1ns/1ps
module nidc_node #(
  parameter int CHECK_CYCLES = nidc_pkg::CHECK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [nidc_pkg::ADDR_W-1:0] node_address,
  input wire logic ack_suppress,
  input wire logic rx_valid,
  input wire nidc_pkg::nidc_frame_s rx_frame,
  output logic tx_valid,
  output nidc_pkg::nidc_frame_s tx_frame,
  input wire logic tx_ready,
  input wire logic bus_off,
  input wire logic app_tx_valid,
  input wire nidc_pkg::nidc_kind_e app_tx_kind,
  output logic app_tx_ready,
  output logic internal_error,
  output logic rx_out_valid,
  output nidc_pkg::nidc_msg_s rx_out,
  output logic reply_due,
  output nidc_pkg::nidc_state_e node_state
);
  localparam logic [nidc_pkg::TMR_W-1:0] TMR_LOAD = nidc_pkg::TMR_W'(CHECK_CYCLES - 1);

  nidc_pkg::nidc_state_s s_r;
  nidc_pkg::nidc_state_s s_nxt;
  nidc_pkg::nidc_kind_e rx_kind;
  nidc_pkg::nidc_kind_e enc_kind;
  logic [nidc_pkg::ID_W-1:0] enc_id;
  logic enc_legal;
  logic rx_dup;
  logic checking;
  logic expire;
  logic first_r;

  // Encoder is shared: the application only while on-line with no check message in, else check frames
  assign enc_kind = (s_r.st == nidc_pkg::ST_ONLINE && !rx_dup) ? app_tx_kind : nidc_pkg::K_DUP;

  nidc_id_codec u_codec (
    .node_address(node_address),
    .rx_id(rx_frame.id),
    .rx_kind(rx_kind),
    .tx_kind(enc_kind),
    .tx_id(enc_id),
    .tx_legal(enc_legal)
  );

  assign rx_dup = rx_valid && (rx_kind == nidc_pkg::K_DUP);
  assign checking = (s_r.st == nidc_pkg::ST_SEND) || (s_r.st == nidc_pkg::ST_WAIT);
  assign expire = (s_r.st == nidc_pkg::ST_WAIT) && (s_r.timer == '0);
  // Application is refused a slot while a frame waits; a pending check answer goes first
  assign app_tx_ready = !s_r.tx_v && !rx_dup;

  always_comb begin
    s_nxt = s_r;
    s_nxt.out_v = 1'b0;
    s_nxt.int_err = 1'b0;
    s_nxt.reply_due = 1'b0;
    // Address is unknown inside reset, so the queued request latches it here
    if (first_r) begin
      s_nxt.tx_f = '{id: enc_id, dup_resp: 1'b0}; // RL14
    end
    if (s_r.tx_v && tx_ready) begin
      s_nxt.tx_v = 1'b0;
    end
    if (s_r.timer != '0) begin
      s_nxt.timer = s_r.timer - 1'b1;
    end
    case (s_r.st)
      nidc_pkg::ST_SEND: begin
        if (s_r.tx_v && tx_ready) begin
          s_nxt.st = nidc_pkg::ST_WAIT; // RL3
          s_nxt.timer = TMR_LOAD; // RL3 RL18
        end
      end
      nidc_pkg::ST_WAIT: begin
        if (expire && !s_r.second) begin
          s_nxt.st = nidc_pkg::ST_SEND; // RL16
          s_nxt.second = 1'b1;
          s_nxt.tx_v = 1'b1;
          s_nxt.tx_f = '{id: enc_id, dup_resp: 1'b0};
        end else if (expire) begin
          s_nxt.st = nidc_pkg::ST_ONLINE; // RL4 RL16
        end
      end
      nidc_pkg::ST_ONLINE: begin
        if (rx_dup && !rx_frame.dup_resp) begin
          // Answer wins over a queued frame that has not yet gone out
          s_nxt.tx_v = 1'b1; // RL17
          s_nxt.tx_f = '{id: enc_id, dup_resp: 1'b1};
        end else if (rx_dup) begin
          s_nxt.st = nidc_pkg::ST_FAULT; // RL2
          s_nxt.tx_v = 1'b0;
        end else if (rx_valid && rx_kind != nidc_pkg::K_NONE) begin
          s_nxt.out_v = 1'b1; // RL12 RL19
          s_nxt.out_m = '{kind: rx_kind, id: rx_frame.id};
          s_nxt.reply_due = (rx_kind == nidc_pkg::K_BS_CMD) ||
                            (rx_kind == nidc_pkg::K_POLL_COS && !ack_suppress); // RL9 RL10 RL11
        end
        if (app_tx_valid && app_tx_ready) begin
          if (enc_legal && enc_kind != nidc_pkg::K_DUP) begin
            s_nxt.tx_v = 1'b1;
            s_nxt.tx_f = '{id: enc_id, dup_resp: 1'b0};
          end else begin
            s_nxt.int_err = 1'b1; // RL12 RL14
          end
        end
      end
      nidc_pkg::ST_FAULT: begin
        s_nxt.tx_v = 1'b0;
      end
      default: s_nxt.st = nidc_pkg::ST_FAULT;
    endcase
    if (checking && rx_dup) begin
      s_nxt.st = nidc_pkg::ST_FAULT; // RL2 RL17
      s_nxt.tx_v = 1'b0;
    end
    // Only bus-off counts; error passive is expected when the node is alone
    if (bus_off) begin
      s_nxt.st = nidc_pkg::ST_FAULT; // RL15
      s_nxt.tx_v = 1'b0;
    end
    if (s_r.st != nidc_pkg::ST_ONLINE && app_tx_valid && app_tx_ready) begin
      s_nxt.int_err = 1'b1;
    end
  end

  // Reset starts the check at once with the first request queued
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: nidc_pkg::ST_SEND, second: 1'b0, timer: '0, tx_v: 1'b1,
               tx_f: '{id: '0, dup_resp: 1'b0}, out_v: 1'b0,
               out_m: '{kind: nidc_pkg::K_NONE, id: '0}, int_err: 1'b0,
               reply_due: 1'b0}; // RL1
    end else begin
      s_r <= s_nxt;
    end
  end

  // Queued first request picks up the address on the first edge after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  assign tx_valid = s_r.tx_v;
  assign tx_frame = first_r ? nidc_pkg::nidc_frame_s'{id: enc_id, dup_resp: 1'b0} : s_r.tx_f; // RL14
  assign internal_error = s_r.int_err;
  assign rx_out_valid = s_r.out_v;
  assign rx_out = s_r.out_m;
  assign reply_due = s_r.reply_due;
  assign node_state = s_r.st;

  a_dup_faults_check: assert property (@(posedge clk) disable iff (rst) // RL17
    (checking && rx_dup) |=> (node_state == nidc_pkg::ST_FAULT))
    else $error("check message during checking did not fault");

  a_dup_request_answered: assert property (@(posedge clk) disable iff (rst) // RL17
    (s_r.st == nidc_pkg::ST_ONLINE && rx_dup && !rx_frame.dup_resp && !bus_off)
    |=> (tx_valid && tx_frame.dup_resp && tx_frame.id[2:0] == nidc_pkg::G2_DUP_CHECK))
    else $error("check request on-line not answered");

  a_busoff_faults: assert property (@(posedge clk) disable iff (rst) // RL15
    bus_off |=> (node_state == nidc_pkg::ST_FAULT && !tx_valid))
    else $error("bus-off did not lead to fault");

  a_timer_loaded: assert property (@(posedge clk) disable iff (rst) // RL3
    (s_r.st == nidc_pkg::ST_SEND && tx_valid && tx_ready && !rx_dup && !bus_off)
    |=> (node_state == nidc_pkg::ST_WAIT && s_r.timer == TMR_LOAD))
    else $error("check timer not loaded after request");

  a_first_expiry_resends: assert property (@(posedge clk) disable iff (rst) // RL16
    (expire && !s_r.second && !rx_dup && !bus_off)
    |=> (node_state == nidc_pkg::ST_SEND && tx_valid && s_r.second))
    else $error("first expiry did not resend");

  a_online_entry: assert property (@(posedge clk) disable iff (rst) // RL4
    (node_state == nidc_pkg::ST_ONLINE && $past(node_state) != nidc_pkg::ST_ONLINE)
    |-> ($past(s_r.second) && $past(expire)))
    else $error("on-line entered without two expiries");

  a_deliver_online: assert property (@(posedge clk) disable iff (rst) // RL12
    rx_out_valid |-> ($past(node_state) == nidc_pkg::ST_ONLINE && rx_out.kind != nidc_pkg::K_NONE))
    else $error("frame delivered while not on-line");

  a_group1_ignored: assert property (@(posedge clk) disable iff (rst) // RL5
    (rx_valid && !rx_frame.id[nidc_pkg::G1_BIT]) |=> !rx_out_valid)
    else $error("group 1 frame delivered");

  a_tx_in_set: assert property (@(posedge clk) disable iff (rst) // RL6
    (tx_valid && !first_r) |-> ((tx_frame.id[10:9] == nidc_pkg::G2_PREFIX &&
      tx_frame.id[8:3] == node_address) ||
      (!tx_frame.id[10] && tx_frame.id[9:8] == 2'h3 && tx_frame.id[7:6] != 2'h0)))
    else $error("transmitted identifier outside the set");

  a_bs_reply_due: assert property (@(posedge clk) disable iff (rst) // RL9
    (node_state == nidc_pkg::ST_ONLINE && rx_valid && !bus_off &&
      rx_kind == nidc_pkg::K_BS_CMD)
    |=> (rx_out_valid && reply_due))
    else $error("bit-strobe command not flagged for reply");

  a_poll_reply_due: assert property (@(posedge clk) disable iff (rst) // RL10
    (node_state == nidc_pkg::ST_ONLINE && rx_valid && !bus_off && !ack_suppress &&
      rx_kind == nidc_pkg::K_POLL_COS)
    |=> (rx_out_valid && reply_due))
    else $error("poll command not flagged for reply");

  a_ack_suppressed: assert property (@(posedge clk) disable iff (rst) // RL11
    (node_state == nidc_pkg::ST_ONLINE && rx_valid && !bus_off && ack_suppress &&
      rx_kind == nidc_pkg::K_POLL_COS)
    |=> (rx_out_valid && !reply_due))
    else $error("suppressed acknowledge still flagged");

  a_foreign_ignored: assert property (@(posedge clk) disable iff (rst) // RL19
    (rx_valid && rx_frame.id[nidc_pkg::G2_ADDR_HI:nidc_pkg::G2_ADDR_LO] != node_address &&
      rx_frame.id[2:0] != nidc_pkg::G2_BS_CMD)
    |=> !rx_out_valid)
    else $error("frame for another address delivered");

  a_refused_offline: assert property (@(posedge clk) disable iff (rst) // RL4
    (app_tx_valid && app_tx_ready && node_state != nidc_pkg::ST_ONLINE)
    |=> internal_error)
    else $error("send request off-line not refused");

  a_fault_silent: assert property (@(posedge clk) disable iff (rst) // RL15
    (node_state == nidc_pkg::ST_FAULT) |-> !tx_valid)
    else $error("frame offered in fault state");
endmodule : nidc_node

// [inc/nidc_pkg.sv]
// Package: identifier map, check timing and carrier types for node address checking
// Summary of operation
// RL1: Node always runs the duplicate address check
// RL2: Accept check messages carrying own address
// RL3: Wait one second after each request
// RL4: On-line only after two unanswered requests
// RL5: Group 1: bit 10 clear, code, source
// RL6: Group 2: prefix 10, address, 3-bit code
// RL7: Code 011 carries the responding slave's address
// RL8: Codes 010,100,101,110,111 carry destination address
// RL9: Bit-strobe command answered by each slave
// RL10: Poll command answered by addressed slave
// RL11: Change-of-state acknowledged unless suppressed
// RL12: Only predefined set identifiers, others ignored
// RL13: Unconnected requests allocate and release set
// RL14: Check uses its own Group 2 code
// RL15: Only bus-off fails a check transmission
// RL16: First expiry resends, second goes on-line
// RL17: On-line answers requests; checking faults
// RL18: Check timer within 0.9 s to 1.5 s
// RL19: Filter on prefix, code and own address
package nidc_pkg;
  localparam int ADDR_W = 6;
  localparam int ID_W = 11;
  localparam int G1_BIT = 10;
  localparam int G1_CODE_HI = 9;
  localparam int G1_CODE_LO = 6;
  localparam int G2_ADDR_HI = 8;
  localparam int G2_ADDR_LO = 3;
  localparam logic [1:0] G2_PREFIX = 2'h2;
  localparam logic [3:0] G1_SL_COS = 4'hd;
  localparam logic [3:0] G1_SL_BS_RESP = 4'he;
  localparam logic [3:0] G1_SL_POLL_RESP = 4'hf;
  localparam logic [2:0] G2_BS_CMD = 3'h0;
  localparam logic [2:0] G2_RESERVED = 3'h1;
  localparam logic [2:0] G2_COS_ACK = 3'h2;
  localparam logic [2:0] G2_EXP_RESP = 3'h3;
  localparam logic [2:0] G2_EXP_REQ = 3'h4;
  localparam logic [2:0] G2_POLL_COS = 3'h5;
  localparam logic [2:0] G2_UNCON_REQ = 3'h6;
  localparam logic [2:0] G2_DUP_CHECK = 3'h7;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CHECK_TIME_NS = 1000000000;
  localparam int CHECK_MIN_NS = 900000000;
  localparam int CHECK_MAX_NS = 1500000000;
  localparam int CHECK_CYCLES = CHECK_TIME_NS / CLK_PERIOD_NS;
  localparam int CHECK_MIN_CYCLES = (CHECK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHECK_MAX_CYCLES = CHECK_MAX_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 28;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_BS_CMD = 4'h1,
    K_COS_ACK = 4'h2,
    K_EXP_REQ = 4'h3,
    K_POLL_COS = 4'h4,
    K_UNCON_REQ = 4'h5,
    K_DUP = 4'h6,
    K_SL_COS = 4'h7,
    K_SL_BS_RESP = 4'h8,
    K_SL_POLL_RESP = 4'h9,
    K_SL_EXP_RESP = 4'ha
  } nidc_kind_e;

  typedef enum logic [1:0] {
    ST_SEND = 2'h0,
    ST_WAIT = 2'h1,
    ST_ONLINE = 2'h2,
    ST_FAULT = 2'h3
  } nidc_state_e;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic dup_resp;
  } nidc_frame_s;

  typedef struct packed {
    nidc_kind_e kind;
    logic [ID_W-1:0] id;
  } nidc_msg_s;

  typedef struct packed {
    nidc_state_e st;
    logic second;
    logic [TMR_W-1:0] timer;
    logic tx_v;
    nidc_frame_s tx_f;
    logic out_v;
    nidc_msg_s out_m;
    logic int_err;
    logic reply_due;
  } nidc_state_s;
endpackage : nidc_pkg

// [hdl/nidc_id_codec.sv]
// Identifier decode and encode for the predefined master/slave set
`timescale 1ns/1ps
module nidc_id_codec (
  input wire logic [nidc_pkg::ADDR_W-1:0] node_address,
  input wire logic [nidc_pkg::ID_W-1:0] rx_id,
  output nidc_pkg::nidc_kind_e rx_kind,
  input wire nidc_pkg::nidc_kind_e tx_kind,
  output logic [nidc_pkg::ID_W-1:0] tx_id,
  output logic tx_legal
);
  logic [nidc_pkg::ADDR_W-1:0] rx_addr;
  logic [2:0] rx_code;
  logic own;

  assign rx_addr = rx_id[nidc_pkg::G2_ADDR_HI:nidc_pkg::G2_ADDR_LO];
  assign rx_code = rx_id[2:0];
  assign own = (rx_addr == node_address);

  always_comb begin
    rx_kind = nidc_pkg::K_NONE;
    // Group 1 traffic is other slaves' output; a Group 2 only slave ignores it
    if (rx_id[10:9] == nidc_pkg::G2_PREFIX) begin // RL6 RL19
      case (rx_code)
        nidc_pkg::G2_BS_CMD: rx_kind = nidc_pkg::K_BS_CMD; // RL9
        nidc_pkg::G2_COS_ACK: rx_kind = own ? nidc_pkg::K_COS_ACK : nidc_pkg::K_NONE; // RL8
        nidc_pkg::G2_EXP_REQ: rx_kind = own ? nidc_pkg::K_EXP_REQ : nidc_pkg::K_NONE; // RL8
        nidc_pkg::G2_POLL_COS: rx_kind = own ? nidc_pkg::K_POLL_COS : nidc_pkg::K_NONE; // RL10
        nidc_pkg::G2_UNCON_REQ: rx_kind = own ? nidc_pkg::K_UNCON_REQ : nidc_pkg::K_NONE; // RL13
        nidc_pkg::G2_DUP_CHECK: rx_kind = own ? nidc_pkg::K_DUP : nidc_pkg::K_NONE; // RL2 RL14
        default: rx_kind = nidc_pkg::K_NONE; // RL7 RL12
      endcase
    end
  end

  always_comb begin
    tx_id = '0;
    tx_legal = 1'b1;
    case (tx_kind)
      nidc_pkg::K_SL_COS: tx_id = {1'b0, nidc_pkg::G1_SL_COS, node_address}; // RL5
      nidc_pkg::K_SL_BS_RESP: tx_id = {1'b0, nidc_pkg::G1_SL_BS_RESP, node_address}; // RL5
      nidc_pkg::K_SL_POLL_RESP: tx_id = {1'b0, nidc_pkg::G1_SL_POLL_RESP, node_address}; // RL5
      nidc_pkg::K_SL_EXP_RESP: tx_id = {nidc_pkg::G2_PREFIX, node_address,
                                        nidc_pkg::G2_EXP_RESP}; // RL7
      nidc_pkg::K_DUP: tx_id = {nidc_pkg::G2_PREFIX, node_address,
                                nidc_pkg::G2_DUP_CHECK}; // RL14
      default: tx_legal = 1'b0; // RL12
    endcase
  end
endmodule : nidc_id_codec

// [bench/nidc_bus_model.sv]
// Model of the CAN controller and far nodes taking frames from the node
`timescale 1ns/1ps
module nidc_bus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire nidc_pkg::nidc_frame_s tx_frame,
  input wire logic [3:0] delay,
  output logic tx_ready,
  output logic [7:0] n_taken,
  output nidc_pkg::nidc_frame_s last_frame
);
  logic [3:0] cnt;
  initial tx_ready = 1'b0;
  // Slow answers stall the node with its frame held up
  always @(negedge clk) begin
    if (rst || tx_ready || !tx_valid) begin
      tx_ready <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt >= delay) begin
      tx_ready <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      n_taken <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      n_taken <= n_taken + 8'h01;
      last_frame <= tx_frame;
    end
  end
endmodule : nidc_bus_model

// [bench/node_id_map_and_dup_check_tb.sv]
// Self-checking bench for address check, receive filter and transmit encode
`timescale 1ns/1ps
module node_id_map_and_dup_check_tb;
  localparam int CYC = 20;
  localparam logic [5:0] ADDR = 6'h2a;
  logic clk, rst, ack_suppress, rx_valid, tx_valid, tx_ready, bus_off, app_tx_valid;
  logic app_tx_ready, internal_error, rx_out_valid, reply_due;
  logic [5:0] node_address;
  logic [3:0] delay;
  logic [7:0] n_taken;
  nidc_pkg::nidc_frame_s rx_frame, tx_frame, last_frame;
  nidc_pkg::nidc_kind_e app_tx_kind;
  nidc_pkg::nidc_msg_s rx_out;
  nidc_pkg::nidc_state_e node_state;
  int n_mismatch, checked;

  nidc_node #(.CHECK_CYCLES(CYC)) uut (.clk(clk), .rst(rst), .node_address(node_address),
    .ack_suppress(ack_suppress), .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .tx_ready(tx_ready), .bus_off(bus_off), .app_tx_valid(app_tx_valid),
    .app_tx_kind(app_tx_kind), .app_tx_ready(app_tx_ready), .internal_error(internal_error),
    .rx_out_valid(rx_out_valid), .rx_out(rx_out), .reply_due(reply_due),
    .node_state(node_state));
  nidc_bus_model bm (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .delay(delay), .tx_ready(tx_ready), .n_taken(n_taken), .last_frame(last_frame));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset

  task automatic wait_state(input nidc_pkg::nidc_state_e st);
    int i;
    for (i = 0; i < 200 && node_state !== st; i++) @(negedge clk);
    if (node_state !== st) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : wait_state

  task automatic send(input logic [10:0] id, input logic resp);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_frame = '{id: id, dup_resp: resp};
    @(negedge clk);
    rx_valid = 1'b0;
  endtask : send

  task automatic app(input nidc_pkg::nidc_kind_e k);
    @(negedge clk);
    app_tx_valid = 1'b1;
    app_tx_kind = k;
    @(negedge clk);
    app_tx_valid = 1'b0;
  endtask : app

  task automatic t_check;
    int w;
    do_reset();
    check(node_state, nidc_pkg::ST_SEND);
    check(tx_frame, {nidc_pkg::G2_PREFIX, ADDR, nidc_pkg::G2_DUP_CHECK, 1'b0});
    delay = 4'h3;
    @(negedge clk);
    check(tx_frame, {nidc_pkg::G2_PREFIX, ADDR, nidc_pkg::G2_DUP_CHECK, 1'b0});
    wait_state(nidc_pkg::ST_WAIT);
    for (w = 0; w < 100 && node_state === nidc_pkg::ST_WAIT; w++) @(negedge clk);
    check(w >= CYC - 1 && w <= CYC + 1, 1'b1);
    check(node_state, nidc_pkg::ST_SEND);
    wait_state(nidc_pkg::ST_ONLINE);
    check(n_taken, 8'h02);
    check(last_frame, {nidc_pkg::G2_PREFIX, ADDR, nidc_pkg::G2_DUP_CHECK, 1'b0});
    delay = 4'h0;
    $display("test check sequence done");
  endtask : t_check

  // Codes 001 and 011 must never be delivered
  function automatic nidc_pkg::nidc_kind_e exp_kind(input int c);
    case (c)
      0: return nidc_pkg::K_BS_CMD;
      2: return nidc_pkg::K_COS_ACK;
      4: return nidc_pkg::K_EXP_REQ;
      5: return nidc_pkg::K_POLL_COS;
      6: return nidc_pkg::K_UNCON_REQ;
      default: return nidc_pkg::K_NONE;
    endcase
  endfunction : exp_kind

  task automatic t_filter;
    int a, o, c;
    logic [10:0] id;
    logic v;
    for (a = 0; a < 2; a++) begin
      ack_suppress = a[0];
      for (o = 0; o < 2; o++) begin
        for (c = 0; c < 7; c++) begin
          id = {nidc_pkg::G2_PREFIX, ADDR ^ 6'(o), 3'(c)};
          v = exp_kind(c) != nidc_pkg::K_NONE && (c == 0 || o == 0);
          send(id, 1'b0);
          check(rx_out_valid, v);
          if (v) check(rx_out, {exp_kind(c), id});
          check(reply_due, v && (c == 0 || (c == 5 && a == 0)));
        end
      end
    end
    send({1'b0, nidc_pkg::G1_SL_POLL_RESP, ADDR}, 1'b0);
    check(rx_out_valid, 1'b0);
    ack_suppress = 1'b0;
    $display("test receive filter done");
  endtask : t_filter

  task automatic t_app;
    app(nidc_pkg::K_SL_COS);
    check(tx_frame, {1'b0, nidc_pkg::G1_SL_COS, ADDR, 1'b0});
    check(app_tx_ready, 1'b0);
    repeat (2) @(negedge clk);
    app(nidc_pkg::K_SL_BS_RESP);
    check(tx_frame, {1'b0, nidc_pkg::G1_SL_BS_RESP, ADDR, 1'b0});
    repeat (2) @(negedge clk);
    app(nidc_pkg::K_SL_POLL_RESP);
    check(tx_frame, {1'b0, nidc_pkg::G1_SL_POLL_RESP, ADDR, 1'b0});
    repeat (2) @(negedge clk);
    app(nidc_pkg::K_SL_EXP_RESP);
    check(tx_frame, {nidc_pkg::G2_PREFIX, ADDR, nidc_pkg::G2_EXP_RESP, 1'b0});
    repeat (2) @(negedge clk);
    app(nidc_pkg::K_POLL_COS);
    check({internal_error, tx_valid}, 2'h2);
    $display("test application transmit done");
  endtask : t_app

  task automatic t_dup;
    send({nidc_pkg::G2_PREFIX, ADDR, nidc_pkg::G2_DUP_CHECK}, 1'b0);
    check({tx_valid, tx_frame}, {1'b1, nidc_pkg::G2_PREFIX, ADDR, 3'h7, 1'b1});
    repeat (2) @(negedge clk);
    send({nidc_pkg::G2_PREFIX, ADDR, nidc_pkg::G2_DUP_CHECK}, 1'b1);
    check(node_state, nidc_pkg::ST_FAULT);
    app(nidc_pkg::K_SL_COS);
    check(internal_error, 1'b1);
    do_reset();
    send({nidc_pkg::G2_PREFIX, ADDR, nidc_pkg::G2_DUP_CHECK}, 1'b0);
    check(node_state, nidc_pkg::ST_FAULT);
    do_reset();
    @(negedge clk);
    bus_off = 1'b1;
    @(negedge clk);
    bus_off = 1'b0;
    check(node_state, nidc_pkg::ST_FAULT);
    $display("test duplicate and fault done");
  endtask : t_dup

  initial begin
    rst = 1'b1;
    node_address = ADDR;
    ack_suppress = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
    bus_off = 1'b0;
    app_tx_valid = 1'b0;
    app_tx_kind = nidc_pkg::K_NONE;
    delay = 4'h0;
    n_mismatch = 0;
    checked = 0;
    t_check();
    t_filter();
    t_app();
    t_dup();
    end_of_test();
  end
endmodule : node_id_map_and_dup_check_tb
